// file: dssc_pkg.sv
// Shared constants and types for the disc sector sensing counter
package dssc_pkg;

    // Servo timing: sector clock transitions in one revolution
    localparam int TRANS_PER_REV = 53760;
    // Physical sectors on one track
    localparam int SECTORS = 64;
    // Highest head address, nine data heads
    localparam int MAX_HEAD = 8;
    // Highest cylinder address
    localparam int MAX_CYL = 822;
    // Cylinder positions ensured usable for data
    localparam int USABLE_CYLS = 815;

    // Field widths of an address as the controller presents it
    localparam int CYL_W = 10;
    localparam int HEAD_W = 5;
    localparam int SEC_W = 8;
    // Width of the present physical sector number
    localparam int PSEC_W = 6;

    // Values after reset
    localparam logic [PSEC_W-1:0] PSEC_RST = 6'h00;
    localparam logic [CYL_W-1:0] CYL_RST = 10'h000;
    localparam logic [HEAD_W-1:0] HEAD_RST = 5'h00;
    localparam logic [SEC_W-1:0] SEC_RST = 8'h00;

    // Cylinder, head and sector address
    typedef struct packed {
        logic [CYL_W-1:0] cyl;
        logic [HEAD_W-1:0] head;
        logic [SEC_W-1:0] sector;
    } dssc_addr_t;

    // Range checks of a loaded address
    typedef struct packed {
        logic cyl_ok;
        logic head_ok;
        logic sector_ok;
        logic cyl_usable;
    } dssc_check_t;

    // Counter lock state
    typedef enum logic {
        DSSC_WAIT_INDEX,
        DSSC_TRACKING
    } dssc_state_t;

endpackage

// file: dssc_sector_counter.sv
// Sector sensing counter: tracks the physical sector under the heads
// Function
// (R1) Locate sector by counting servo sector clock transitions, fixed count per revolution.
// (R2) Index pattern clears the transition counter, counting resumes next revolution.
// (R3) Index detection marks the start of physical sector zero.
// (R4) Valid sector addresses run from zero to sector count minus one.
// (R5) Valid head addresses run zero through eight, nine data heads.
// (R6) Cylinder addresses run zero to maximum; fewer are ensured usable.
// (R7) Track needs cylinder and head; sector needs head and sector.
// (R8) Controller staggers logical sectors track to track.
// (R9) Controller maps logical to physical sector before addressing the drive.
// (R10) Controller inverse-maps the reported present physical sector.
// (R11) Signal match of present and addressed sector; match enables read/write.
// (R12) Present sector advances after each equal share of transitions.
// (R13) Present sector held stable; read without partial update.
`timescale 1ns/1ns
module dssc_sector_counter #(
    parameter int TRANS_PER_REV = dssc_pkg::TRANS_PER_REV,
    parameter int SECTORS = dssc_pkg::SECTORS
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // Servo pins, asynchronous
    input wire logic SECTOR_CLK,
    input wire logic INDEX,
    // Address from the controller
    input wire logic ADDR_LOAD,
    input wire dssc_pkg::dssc_addr_t ADDR,
    // Present sector request
    input wire logic SECTOR_REQ,
    // Position state
    output logic [dssc_pkg::PSEC_W-1:0] PRESENT_SECTOR,
    output logic POS_VALID,
    output logic INDEX_MISSING,
    // Address state
    output dssc_pkg::dssc_addr_t SEL_ADDR,
    output dssc_pkg::dssc_check_t ADDR_CHECK,
    // Match and transfer enable
    output logic SECTOR_MATCH,
    output logic RW_ENABLE,
    // Reported sector
    output logic [dssc_pkg::PSEC_W-1:0] SECTOR_REPORT,
    output logic REPORT_VALID
);

    localparam int PER_SEC = TRANS_PER_REV / SECTORS;
    localparam int CW = (PER_SEC > 1) ? $clog2(PER_SEC) : 1;
    localparam int SW = dssc_pkg::PSEC_W;
    localparam logic [CW-1:0] CNT_LAST = CW'(PER_SEC - 1);
    localparam logic [SW-1:0] SEC_LAST = SW'(SECTORS - 1);

    // Elaboration check on the revolution shape
    if (SECTORS != (1 << SW) || PER_SEC < 2 || PER_SEC * SECTORS != TRANS_PER_REV) begin : g_chk
        $error("dssc_sector_counter: transitions must split evenly over 64 sectors");
    end

    logic sclk_s1, sclk_s2, sclk_s3;
    logic idx_s1, idx_s2, idx_s3;
    dssc_pkg::dssc_state_t state_reg, state_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [SW-1:0] sec_reg, sec_next;
    logic miss_reg, miss_next;
    dssc_pkg::dssc_addr_t addr_reg;
    dssc_pkg::dssc_check_t chk_reg;
    logic match_reg, rw_reg;
    logic [SW-1:0] rep_reg;
    logic rep_valid_reg;

    // Synchronisers for the servo pins
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
            {idx_s1, idx_s2, idx_s3} <= 3'h0;
        end else begin
            {sclk_s1, sclk_s2, sclk_s3} <= {SECTOR_CLK, sclk_s1, sclk_s2};
            {idx_s1, idx_s2, idx_s3} <= {INDEX, idx_s1, idx_s2};
        end
    end

    // Edge events and counter decode
    wire tick = sclk_s2 & ~sclk_s3;
    wire idx_hit = idx_s2 & ~idx_s3;
    wire tracking = (state_reg == dssc_pkg::DSSC_TRACKING);
    wire cnt_end = (cnt_reg == CNT_LAST);
    wire sec_end = (sec_reg == SEC_LAST);
    wire step = tracking & tick & ~idx_hit;

    // Lock state: counting starts at the first index
    always_comb begin
        case (state_reg)
            dssc_pkg::DSSC_WAIT_INDEX: state_next = idx_hit ? dssc_pkg::DSSC_TRACKING
                                                            : dssc_pkg::DSSC_WAIT_INDEX;
            dssc_pkg::DSSC_TRACKING: state_next = dssc_pkg::DSSC_TRACKING;
            default: state_next = dssc_pkg::DSSC_WAIT_INDEX;
        endcase
    end

    // Transition and sector counting
    always_comb begin
        cnt_next = cnt_reg;
        sec_next = sec_reg;
        miss_next = miss_reg;
        if (idx_hit) begin
            cnt_next = '0; // see (R2)
            sec_next = dssc_pkg::PSEC_RST; // see (R3)
            miss_next = 1'b0;
        end else if (step) begin
            if (cnt_end) begin
                cnt_next = '0;
                if (sec_end) begin
                    miss_next = 1'b1; // Revolution overran, hold last sector
                end else begin
                    sec_next = sec_reg + SW'(1); // see (R12)
                end
            end else begin
                cnt_next = cnt_reg + CW'(1); // see (R1)
            end
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state_reg <= dssc_pkg::DSSC_WAIT_INDEX;
            cnt_reg <= '0;
            sec_reg <= dssc_pkg::PSEC_RST;
            miss_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            sec_reg <= sec_next; // see (R13)
            miss_reg <= miss_next;
        end
    end

    // Range checks on the offered address
    wire chk_cyl = (ADDR.cyl <= dssc_pkg::CYL_W'(dssc_pkg::MAX_CYL)); // see (R6)
    wire chk_use = (ADDR.cyl < dssc_pkg::CYL_W'(dssc_pkg::USABLE_CYLS)); // see (R6)
    wire chk_head = (ADDR.head <= dssc_pkg::HEAD_W'(dssc_pkg::MAX_HEAD)); // see (R5)
    wire chk_sec = (ADDR.sector < dssc_pkg::SEC_W'(SECTORS)); // see (R4)

    // Addressed cylinder, head and sector
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            addr_reg <= '{cyl: dssc_pkg::CYL_RST, head: dssc_pkg::HEAD_RST,
                          sector: dssc_pkg::SEC_RST};
            chk_reg <= '0;
        end else if (ADDR_LOAD) begin
            addr_reg <= ADDR;
            chk_reg <= '{cyl_ok: chk_cyl, head_ok: chk_head, sector_ok: chk_sec,
                         cyl_usable: chk_use};
        end
    end

    // Match of present and addressed sector
    wire sec_eq = chk_reg.sector_ok & (addr_reg.sector[SW-1:0] == sec_reg);
    wire match_next = tracking & ~miss_reg & sec_eq; // see (R11)
    wire rw_next = match_next & chk_reg.cyl_ok & chk_reg.head_ok; // see (R7)

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            match_reg <= 1'b0;
            rw_reg <= 1'b0;
        end else begin
            match_reg <= match_next;
            rw_reg <= rw_next;
        end
    end

    // Snapshot of the present sector on request
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            rep_reg <= dssc_pkg::PSEC_RST;
            rep_valid_reg <= 1'b0;
        end else begin
            rep_valid_reg <= SECTOR_REQ;
            if (SECTOR_REQ) begin
                rep_reg <= sec_reg; // see (R13)
            end
        end
    end

    // Outputs
    assign PRESENT_SECTOR = sec_reg;
    assign POS_VALID = tracking;
    assign INDEX_MISSING = miss_reg;
    assign SEL_ADDR = addr_reg;
    assign ADDR_CHECK = chk_reg;
    assign SECTOR_MATCH = match_reg;
    assign RW_ENABLE = rw_reg;
    assign SECTOR_REPORT = rep_reg;
    assign REPORT_VALID = rep_valid_reg;

    // Checks on the counting and matching
    a_index_clears: assert property (@(posedge CLOCK) disable iff (RST) // see (R2)
        idx_hit |=> (cnt_reg == '0) && (sec_reg == '0) && tracking)
        else $error("index did not clear the count");
    a_sector_zero: assert property (@(posedge CLOCK) disable iff (RST) // see (R3)
        idx_hit ##1 !tick[*2] |-> (sec_reg == '0))
        else $error("sector zero not held after index");
    a_count_step: assert property (@(posedge CLOCK) disable iff (RST) // see (R1)
        (step && !cnt_end) |=> (cnt_reg == $past(cnt_reg) + CW'(1)))
        else $error("transition not counted");
    a_sector_step: assert property (@(posedge CLOCK) disable iff (RST) // see (R12)
        (step && cnt_end && !sec_end) |=> (sec_reg == $past(sec_reg) + SW'(1))
        && (cnt_reg == '0))
        else $error("sector did not advance on share end");
    a_sector_stable: assert property (@(posedge CLOCK) disable iff (RST) // see (R13)
        (!tick && !idx_hit) |=> $stable(sec_reg))
        else $error("sector changed without a transition");
    a_report_snap: assert property (@(posedge CLOCK) disable iff (RST) // see (R13)
        SECTOR_REQ |=> REPORT_VALID && (SECTOR_REPORT == $past(sec_reg)))
        else $error("report does not hold requested sector");
    a_head_range: assert property (@(posedge CLOCK) disable iff (RST) // see (R5)
        ADDR_LOAD |=> (chk_reg.head_ok == ($past(ADDR.head) <= 5'h08)))
        else $error("head range check wrong");
    a_cyl_range: assert property (@(posedge CLOCK) disable iff (RST) // see (R6)
        ADDR_LOAD |=> (chk_reg.cyl_ok == ($past(ADDR.cyl) <= 10'h336))
        && (chk_reg.cyl_usable == ($past(ADDR.cyl) <= 10'h32E)))
        else $error("cylinder range check wrong");
    a_sector_range: assert property (@(posedge CLOCK) disable iff (RST) // see (R4)
        ADDR_LOAD |=> (chk_reg.sector_ok == ($past(ADDR.sector) <= 8'h3F)))
        else $error("sector range check wrong");
    // Enable is one cycle behind the checks, so compare with the checks it was built from
    a_match_rw: assert property (@(posedge CLOCK) disable iff (RST) // see (R11)
        RW_ENABLE |-> SECTOR_MATCH && $past(chk_reg.cyl_ok) && $past(chk_reg.head_ok))
        else $error("transfer enabled without match and track");
    a_match_time: assert property (@(posedge CLOCK) disable iff (RST) // see (R11)
        (tracking && !miss_reg && sec_eq) |=> SECTOR_MATCH)
        else $error("match not signalled");
    a_match_drop: assert property (@(posedge CLOCK) disable iff (RST) // see (R11)
        (addr_reg.sector[SW-1:0] != sec_reg) |=> !SECTOR_MATCH)
        else $error("match shown for another sector");

endmodule

// file: dssc_ctrl_model.sv
// Controller model: sector mapping and address and report strobes
`timescale 1ns/1ns
module dssc_ctrl_model #(
    parameter int SKEW = 2
) (
    // Clock
    input wire logic clock,
    // Requests to the drive
    output dssc_pkg::dssc_addr_t addr,
    output logic addr_load,
    output logic sector_req
);
    // Strobes idle from time zero
    initial begin
        addr = '0;
        addr_load = 1'b0;
        sector_req = 1'b0;
    end

    // Logical to physical, staggered by head
    function automatic logic [7:0] to_phys(input logic [4:0] head, input logic [7:0] lsec);
        to_phys = 8'((lsec + SKEW * head) % dssc_pkg::SECTORS);
    endfunction

    // Physical back to logical
    function automatic logic [7:0] to_log(input logic [4:0] head, input logic [7:0] psec);
        to_log = 8'((psec + 9 * dssc_pkg::SECTORS - SKEW * head) % dssc_pkg::SECTORS);
    endfunction

    // One-cycle address strobe, bus shows junk once released
    task automatic send(input logic [9:0] cyl, input logic [4:0] head, input logic [7:0] psec);
        @(posedge clock);
        addr <= {cyl, head, psec};
        addr_load <= 1'b1;
        @(posedge clock);
        addr <= ~{cyl, head, psec};
        addr_load <= 1'b0;
    endtask

    // One-cycle present sector request
    task automatic ask();
        @(posedge clock);
        sector_req <= 1'b1;
        @(posedge clock);
        sector_req <= 1'b0;
    endtask
endmodule

// file: disc_sector_sensing_counter_tb_top.sv
// Testbench for the disc sector sensing counter
`timescale 1ns/1ns
module disc_sector_sensing_counter_tb_top;
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    logic SECTOR_CLK = 1'b0;
    logic INDEX = 1'b0;
    logic ADDR_LOAD;
    logic SECTOR_REQ;
    dssc_pkg::dssc_addr_t ADDR;
    logic [5:0] PRESENT_SECTOR;
    logic [5:0] SECTOR_REPORT;
    logic POS_VALID, SECTOR_MATCH, RW_ENABLE, REPORT_VALID, INDEX_MISSING;
    dssc_pkg::dssc_addr_t SEL_ADDR;
    dssc_pkg::dssc_check_t ADDR_CHECK;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;

    // Four transitions per sector
    dssc_sector_counter #(.TRANS_PER_REV(256), .SECTORS(64)) uut (
        .CLOCK(CLOCK), .RST(RST), .SECTOR_CLK(SECTOR_CLK), .INDEX(INDEX),
        .ADDR_LOAD(ADDR_LOAD), .ADDR(ADDR), .SECTOR_REQ(SECTOR_REQ),
        .PRESENT_SECTOR(PRESENT_SECTOR), .POS_VALID(POS_VALID), .INDEX_MISSING(INDEX_MISSING),
        .SEL_ADDR(SEL_ADDR), .ADDR_CHECK(ADDR_CHECK), .SECTOR_MATCH(SECTOR_MATCH),
        .RW_ENABLE(RW_ENABLE), .SECTOR_REPORT(SECTOR_REPORT), .REPORT_VALID(REPORT_VALID));
    dssc_ctrl_model ctrl (.clock(CLOCK), .addr(ADDR), .addr_load(ADDR_LOAD),
        .sector_req(SECTOR_REQ));

    // Clock and hang guard
    initial forever #20 CLOCK = ~CLOCK;
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Servo transitions, 2 high and 2 low cycles each
    task automatic spin(input int n);
        @(posedge CLOCK);
        repeat (n) begin
            SECTOR_CLK <= 1'b1;
            repeat (2) @(posedge CLOCK);
            SECTOR_CLK <= 1'b0;
            repeat (2) @(posedge CLOCK);
        end
        repeat (6) @(posedge CLOCK);
        #1;
    endtask

    task automatic index_pulse();
        @(posedge CLOCK);
        INDEX <= 1'b1;
        repeat (2) @(posedge CLOCK);
        INDEX <= 1'b0;
        repeat (6) @(posedge CLOCK);
        #1;
    endtask

    // Counting before and after the first index
    task automatic test_count();
        spin(4);
        check(POS_VALID, 1'b0);
        check(PRESENT_SECTOR, 6'h00);
        index_pulse();
        check(POS_VALID, 1'b1);
        check(PRESENT_SECTOR, 6'h00);
        spin(3);
        check(PRESENT_SECTOR, 6'h00);
        spin(1);
        check(PRESENT_SECTOR, 6'h01);
    endtask

    // Range flags at the boundaries
    task automatic test_ranges();
        logic [9:0] cy[4] = '{10'h336, 10'h337, 10'h32E, 10'h32F};
        logic [4:0] hd[4] = '{5'h08, 5'h09, 5'h00, 5'h1F};
        logic [7:0] sc[4] = '{8'h3F, 8'h40, 8'h00, 8'hFF};
        for (int i = 0; i < 4; i++) begin
            ctrl.send(cy[i], hd[i], sc[i]);
            #1;
            check(SEL_ADDR, {cy[i], hd[i], sc[i]});
            check(ADDR_CHECK, {cy[i] <= 822, hd[i] <= 8, sc[i] <= 63, cy[i] < 815});
        end
    endtask

    // Match, transfer enable and report; heads sit in sector 2 on entry
    task automatic test_match();
        ctrl.send(10'h064, 5'h01, ctrl.to_phys(5'h01, 8'h01));
        repeat (2) @(posedge CLOCK);
        #1;
        check(SECTOR_MATCH, 1'b0);
        spin(4);
        check({SECTOR_MATCH, RW_ENABLE}, 2'b11);
        ctrl.ask();
        #1;
        check(REPORT_VALID, 1'b1);
        check(ctrl.to_log(5'h01, 8'(SECTOR_REPORT)), 8'h01);
        @(posedge CLOCK);
        #1;
        check(REPORT_VALID, 1'b0);
        ctrl.send(10'h064, 5'h09, 8'h03);
        repeat (2) @(posedge CLOCK);
        #1;
        check({SECTOR_MATCH, RW_ENABLE}, 2'b10);
        index_pulse();
        check({PRESENT_SECTOR, SECTOR_MATCH}, 7'h00);
    endtask

    // Revolution overrun without index, then recovery at the index
    task automatic test_overrun();
        spin(252);
        check({INDEX_MISSING, PRESENT_SECTOR}, 7'h3F);
        spin(4);
        check({INDEX_MISSING, PRESENT_SECTOR}, 7'h7F);
        index_pulse();
        check({INDEX_MISSING, PRESENT_SECTOR, POS_VALID}, 8'h01);
    endtask

    task automatic tally_and_finish();
        if (mismatches == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Reset then scenarios
    initial begin
        repeat (8) @(posedge CLOCK);
        RST <= 1'b0;
        #1;
        check({POS_VALID, PRESENT_SECTOR, REPORT_VALID, INDEX_MISSING}, 9'h000);
        test_count();
        spin(4);
        test_ranges();
        test_match();
        test_overrun();
        tally_and_finish();
    end
endmodule
